/* inc/mbd_pkg.sv */
// Package of shared constants for the multiplexed bus address decoder
package mbd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // Address bit positions used by the decode equations
    localparam int A15_POS = 15;
    localparam int A14_POS = 14;
    localparam int A13_POS = 13;
    localparam int A12_POS = 12;
    // Size of the master's internal RAM overlay in bytes
    localparam int INT_RAM_BYTES = 512;
    // Map base configuration value for the internal register block
    localparam logic [7:0] MAP_BASE_CFG = 8'h08;
    // Region bases
    localparam logic [15:0] RAM_BASE = 16'h0000;
    localparam logic [15:0] REG_BASE = 16'h8000;
    localparam logic [15:0] DAC_BASE = 16'h9000;
    localparam logic [15:0] ROM_BASE = 16'hA000;
    // Boot mode pin level for expanded multiplexed operation
    localparam logic BOOT_EXPANDED = 1'b1;
    // Bus cycle phase counts for the master (address phase, data phase)
    localparam logic [3:0] ADDR_PHASE_CYC = 4'h2;
    localparam logic [3:0] DATA_PHASE_CYC = 4'h2;
endpackage : mbd_pkg

/* inc/mbd_bus_if.sv */
// Interface joining the bus master and the address decoder
`timescale 1ns/1ps
interface mbd_bus_if;
    logic [7:0] addr_hi;
    logic [7:0] mux_addr_data_bus;
    logic address_strobe;
    logic rd_wr;
    logic bus_clk;
    logic boot_mode_pin_a;
    logic boot_mode_pin_b;
    modport master (
        output addr_hi,
        output mux_addr_data_bus,
        output address_strobe,
        output rd_wr,
        output bus_clk,
        output boot_mode_pin_a,
        output boot_mode_pin_b
    );
    modport decoder (
        input addr_hi,
        input mux_addr_data_bus,
        input address_strobe,
        input rd_wr,
        input bus_clk,
        input boot_mode_pin_a,
        input boot_mode_pin_b
    );
endinterface : mbd_bus_if

/* design/mbd_decoder.sv */
// Address latch and select decode between the multiplexed bus and memories
`timescale 1ns/1ps
module mbd_decoder
    import mbd_pkg::*;
(
    mbd_bus_if.decoder bus,
    output logic [15:0] o_addr,
    output logic [7:0] o_data,
    output logic o_ram_select_n,
    output logic o_ram_we_n,
    output logic o_rom_select_n,
    output logic o_rom_ce_n,
    output logic o_rom_addr_bit15,
    output logic o_rom_addr_bit14,
    output logic o_rom_addr_bit13,
    output logic o_rom_addr_bit12,
    output logic o_dac_strobe_n
);
    logic [7:0] low_addr;
    logic [15:0] a;

    always_latch
    begin
        if (bus.address_strobe)
        begin
            low_addr = bus.mux_addr_data_bus;
        end
    end

    always_comb
    begin
        a = {bus.addr_hi, low_addr};
        o_addr = a;
        o_data = bus.mux_addr_data_bus;
        o_ram_select_n = a[A15_POS] | ~bus.bus_clk;
        o_ram_we_n = bus.rd_wr;
        o_rom_select_n = ~a[A15_POS] | (~a[A14_POS] & ~a[A13_POS])
            | ~bus.bus_clk | ~bus.rd_wr;
        o_rom_ce_n = 1'b0;
        o_rom_addr_bit15 = 1'b0;
        o_rom_addr_bit14 = a[A14_POS] & a[A13_POS];
        o_rom_addr_bit13 = ~a[A13_POS];
        o_rom_addr_bit12 = a[A12_POS];
        // DAC strobe, low 12 bits ignored
        o_dac_strobe_n = ~a[A15_POS] | a[A14_POS] | a[A13_POS] | ~a[A12_POS]
            | ~bus.bus_clk;
    end
endmodule : mbd_decoder

/* design/mbd_master.sv */
// Simple multiplexed bus master issuing single read or write cycles
`timescale 1ns/1ps
module mbd_master
    import mbd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_busy,
    output logic o_suppressed,
    mbd_bus_if.master bus
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } mbd_state_e;
    mbd_state_e state_r;
    logic [3:0] cnt_r;
    logic [15:0] addr_r;
    logic [7:0] wdata_r;
    logic write_r;
    logic hide_r;

    function automatic logic is_internal(input logic [15:0] a);
        // internal RAM and register block stay off the bus
        is_internal = (a < 16'(INT_RAM_BYTES)) ||
            (a >= REG_BASE && a < DAC_BASE);
    endfunction : is_internal

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
            write_r <= 1'b0;
            hide_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (i_req)
                    begin
                        addr_r <= i_addr;
                        wdata_r <= i_wdata;
                        write_r <= i_write;
                        hide_r <= is_internal(i_addr);
                        cnt_r <= ADDR_PHASE_CYC - 4'h1;
                        state_r <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        cnt_r <= DATA_PHASE_CYC - 4'h1;
                        state_r <= ST_DATA;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
            endcase
        end
    end

    // high byte on its port, low byte then data on shared lines
    always_comb
    begin
        bus.addr_hi = hide_r ? 8'hFF : addr_r[15:8];
        bus.mux_addr_data_bus = (state_r == ST_DATA) ? wdata_r : addr_r[7:0];
        bus.address_strobe = (state_r == ST_ADDR) && !hide_r;
        bus.rd_wr = !(write_r && state_r == ST_DATA && !hide_r);
        // clock high only in the data phase of an external cycle
        bus.bus_clk = (state_r == ST_DATA) && !hide_r;
        // boot pins select expanded multiplexed mode
        bus.boot_mode_pin_a = BOOT_EXPANDED;
        bus.boot_mode_pin_b = BOOT_EXPANDED;
        o_busy = (state_r != ST_IDLE);
        o_suppressed = hide_r;
    end
endmodule : mbd_master

/* test/mbd_decoder_asserts.sv */
// Checker for the decoder selects and the address latch
`timescale 1ns/1ps
module mbd_decoder_asserts (
    input logic i_clk,
    input logic i_rstn,
    input logic bus_clk,
    input logic rd_wr,
    input logic address_strobe,
    input logic [15:0] o_addr,
    input logic o_ram_select_n,
    input logic o_ram_we_n,
    input logic o_rom_select_n,
    input logic o_rom_ce_n,
    input logic o_rom_addr_bit15,
    input logic o_rom_addr_bit14,
    input logic o_rom_addr_bit13,
    input logic o_dac_strobe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_held;
        $stable(o_addr) ##1 $stable(o_addr);
    endsequence
    AST_LATCH: assert property ($fell(address_strobe) |-> s_held)
        else $error("latched address moved in data phase");
    AST_RAM: assert property (o_ram_select_n == !(!o_addr[15] && bus_clk))
        else $error("ram select wrong");
    AST_WE: assert property (o_ram_we_n == rd_wr)
        else $error("ram write enable wrong");
    AST_ROM: assert property (o_rom_select_n ==
        !(o_addr[15] && (o_addr[14] || o_addr[13]) && bus_clk && rd_wr))
        else $error("rom select wrong");
    AST_RCE: assert property (o_rom_ce_n == 1'b0)
        else $error("rom chip enable released");
    AST_RA: assert property (bus_clk |-> {o_rom_addr_bit15, o_rom_addr_bit14,
        o_rom_addr_bit13} == {1'b0, o_addr[14] & o_addr[13], !o_addr[13]})
        else $error("rom address remap wrong");
    AST_DAC: assert property (o_dac_strobe_n == !(o_addr[15:12] == 4'h9 && bus_clk))
        else $error("dac strobe wrong");
    AST_QUAL: assert property (!bus_clk |->
        o_ram_select_n && o_rom_select_n && o_dac_strobe_n)
        else $error("select active in address phase");
endmodule : mbd_decoder_asserts

/* test/mbd_decoder_tb_top.sv */
// Testbench joining master and decoder through the bus interface
`timescale 1ns/1ps
module mbd_decoder_tb_top;
    import mbd_pkg::*;
    logic i_clk = 0, i_rstn = 0, i_req = 0, i_write = 0, o_busy, o_suppressed;
    logic [15:0] i_addr = '0, seed = 16'h001C, o_addr;
    logic [7:0] i_wdata = '0, o_data;
    logic o_ram_select_n, o_ram_we_n, o_rom_select_n, o_rom_ce_n, o_dac_strobe_n;
    logic o_rom_addr_bit15, o_rom_addr_bit14, o_rom_addr_bit13, o_rom_addr_bit12;
    logic [15:0] corner [12] = '{16'h0000, 16'h01FF, 16'h0200, 16'h7FFF, 16'h8000, 16'h8FFF,
        16'h9000, 16'h9FFF, 16'hA000, 16'hC000, 16'hE000, 16'hFFFF};
    int mismatches = 0, n_tests = 0;
    mbd_bus_if bus();
    mbd_master i_mbd_master (.i_clk, .i_rstn, .i_req, .i_write, .i_addr, .i_wdata, .o_busy,
        .o_suppressed, .bus(bus));
    mbd_decoder i_mbd_decoder (.bus(bus), .o_addr, .o_data, .o_ram_select_n, .o_ram_we_n,
        .o_rom_select_n, .o_rom_ce_n, .o_rom_addr_bit15, .o_rom_addr_bit14, .o_rom_addr_bit13,
        .o_rom_addr_bit12, .o_dac_strobe_n);
    mbd_decoder_asserts i_chk (.i_clk, .i_rstn, .bus_clk(bus.bus_clk), .rd_wr(bus.rd_wr),
        .address_strobe(bus.address_strobe), .o_addr, .o_ram_select_n, .o_ram_we_n,
        .o_rom_select_n, .o_rom_ce_n, .o_rom_addr_bit15, .o_rom_addr_bit14, .o_rom_addr_bit13,
        .o_dac_strobe_n);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Data phase selects and remapped rom address
    function automatic logic [6:0] exp_sel(input logic [15:0] a, input logic rd);
        return {a[15], !(a[15] && (a[14] || a[13]) && rd), a[15:12] != 4'h9, 1'b0,
            a[14] & a[13], !a[13], a[12]};
    endfunction : exp_sel
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    task automatic xfer(input logic [15:0] a, input logic wr);
        logic seen;
        logic ext;
        logic [6:0] sel_seen;
        seen = 1'b0;
        ext = a >= 16'(INT_RAM_BYTES) && a[15:12] != REG_BASE[15:12];
        @(posedge i_clk);
        #1 i_req = 1'b1;
        i_write = wr;
        i_addr = a;
        i_wdata = ~seed[11:4];
        @(posedge i_clk);
        #1 i_req = 1'b0;
        for (int k = 0; k < 8 && o_busy === 1'b1; k++)
        begin
            if (bus.bus_clk === 1'b1)
            begin
                seen = 1'b1;
                chk("addr", a, o_addr);
                sel_seen = {o_ram_select_n, o_rom_select_n, o_dac_strobe_n, o_rom_addr_bit15,
                    o_rom_addr_bit14, o_rom_addr_bit13, o_rom_addr_bit12};
                chk("sel", exp_sel(a, !wr), sel_seen);
                chk("we", !wr, o_ram_we_n);
                if (wr)
                    chk("data", i_wdata, o_data);
            end
            else
                chk("idle", 3'h7, {o_ram_select_n, o_rom_select_n, o_dac_strobe_n});
            @(posedge i_clk);
            #1;
        end
        if (o_busy !== 1'b0)
        begin
            mismatches++;
            summarize();
        end
        chk("phase", ext, seen);
        chk("hide", !ext, o_suppressed);
        chk("romce", 1'h0, o_rom_ce_n);
    endtask : xfer
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (6) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        chk("boot", 2'h3, {bus.boot_mode_pin_a, bus.boot_mode_pin_b});
        foreach (corner[j])
        begin
            xfer(corner[j], 1'b0);
            xfer(corner[j], 1'b1);
        end
        // Reset in the middle of an address phase leaves the bus idle
        @(posedge i_clk);
        #1 i_req = 1'b1;
        i_addr = 16'h4000;
        @(posedge i_clk);
        #1 i_req = 1'b0;
        i_rstn = 1'b0;
        #1 chk("rst", 16'h0001, {o_busy, bus.bus_clk, bus.address_strobe, bus.rd_wr});
        repeat (2) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        repeat (60)
        begin
            seed = lfsr(seed);
            xfer(seed, seed[0]);
        end
        summarize();
    end
endmodule : mbd_decoder_tb_top
